// >>> cpsc_power_seq.v
// Power-state sequencer: full-on, halt, stop grant, sleep and probe
`timescale 1ns/100ps
`include "cpsc_regs.vh"

// Three-flop synchroniser; output follows once stages two and three agree
module cpsc_sync #(
  parameter IDLE = 1'b0
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Pin in, settled level out
  input wire pin,
  output reg level
);
  reg [2:0] stage;

  // Resets to the idle level so no false request follows reset
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage <= {3{IDLE}};
      level <= IDLE;
    end else begin
      stage <= {stage[1:0], pin};
      if (stage[1] == stage[2]) begin
        level <= stage[2];
      end
    end
  end
endmodule

module cpsc_power_seq #(
  parameter [3:0] CORE_VID = `CPSC_CORE_VID_DEFAULT,
  parameter CACHE_SEL_25V = `CPSC_CACHE_SEL_DEFAULT
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Pins from the system, active low, asynchronous
  input wire clock_stop_request_n,
  input wire mgmt_interrupt_n,
  input wire soft_init_n,
  input wire reset_pin_n,
  // Pins from the system, active high, asynchronous
  input wire maskable_irq,
  input wire nmi_irq,
  input wire attach_request,
  input wire sleep_select,
  // Core side, same clock
  input wire halt_instruction,
  input wire irq_enabled,
  input wire bus_busy,
  input wire probe_done,
  input wire irq_taken,
  // Special cycle request to the bus unit
  output reg [1:0] special_cycle,
  output reg special_cycle_valid,
  // State and interrupt reporting
  output reg [2:0] power_state,
  output reg core_run,
  output reg pll_run,
  output reg probe_enable,
  output reg mgmt_mode_enter,
  output reg reset_start,
  output reg [3:0] pending_irq,
  // Supply selection
  output reg cache_supply_select,
  output reg [3:0] core_voltage_code
);
  wire stop_level_n;
  wire mgmt_level_n;
  wire init_level_n;
  wire rst_level_n;
  wire stop_req;
  wire mgmt_req;
  wire init_req;
  wire rst_req;
  wire irq_req;
  wire nmi_req;
  wire att_req;
  wire slp_req;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] return_state;
  reg [2:0] probe_return;
  reg [3:0] latch_irq;
  reg [3:0] next_latch_irq;
  reg [1:0] next_special_cycle;
  reg next_special_valid;
  reg mgmt_prev;
  wire stopped;
  wire [3:0] irq_now;

  // Active-low pins idle high
  cpsc_sync #(.IDLE(1'b1)) u_sync_stop (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin(clock_stop_request_n),
    .level(stop_level_n)
  );
  cpsc_sync #(.IDLE(1'b1)) u_sync_mgmt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin(mgmt_interrupt_n),
    .level(mgmt_level_n)
  );
  cpsc_sync #(.IDLE(1'b1)) u_sync_init (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin(soft_init_n),
    .level(init_level_n)
  );
  cpsc_sync #(.IDLE(1'b1)) u_sync_rst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin(reset_pin_n),
    .level(rst_level_n)
  );
  // Active-high pins idle low
  cpsc_sync #(.IDLE(1'b0)) u_sync_irq (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin(maskable_irq),
    .level(irq_req)
  );
  cpsc_sync #(.IDLE(1'b0)) u_sync_nmi (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin(nmi_irq),
    .level(nmi_req)
  );
  cpsc_sync #(.IDLE(1'b0)) u_sync_att (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin(attach_request),
    .level(att_req)
  );
  cpsc_sync #(.IDLE(1'b0)) u_sync_slp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin(sleep_select),
    .level(slp_req)
  );

  assign stop_req = ~stop_level_n;
  assign mgmt_req = ~mgmt_level_n;
  assign init_req = ~init_level_n;
  assign rst_req = ~rst_level_n;

  assign stopped = (state == `CPSC_ST_STOP_GRANT) || (state == `CPSC_ST_SLEEP);
  assign irq_now = {mgmt_req, nmi_req, irq_req & irq_enabled, init_req};

  // Next power state
  always @* begin
    next_state = state;
    case (state)
      `CPSC_ST_FULL_ON: begin
        if (rst_req) begin
          next_state = `CPSC_ST_FULL_ON;
        end else if (stop_req) begin
          next_state = `CPSC_ST_DRAIN;
        end else if (halt_instruction) begin
          next_state = `CPSC_ST_HALT;
        end
      end
      `CPSC_ST_HALT: begin
        if (rst_req || init_req || nmi_req || mgmt_req || (irq_req && irq_enabled)) begin
          next_state = `CPSC_ST_FULL_ON;
        end else if (att_req) begin
          next_state = `CPSC_ST_PROBE;
        end else if (stop_req) begin
          next_state = `CPSC_ST_DRAIN;
        end
      end
      `CPSC_ST_DRAIN: begin
        if (!stop_req) begin
          next_state = return_state;
        end else if (!bus_busy) begin
          next_state = slp_req ? `CPSC_ST_SLEEP : `CPSC_ST_STOP_GRANT;
        end
      end
      `CPSC_ST_STOP_GRANT: begin
        if (rst_req) begin
          next_state = `CPSC_ST_FULL_ON;
        end else if (!stop_req) begin
          next_state = return_state;
        end else if (att_req) begin
          next_state = `CPSC_ST_PROBE;
        end
      end
      `CPSC_ST_SLEEP: begin
        if (rst_req) begin
          next_state = `CPSC_ST_FULL_ON;
        end else if (!stop_req) begin
          next_state = `CPSC_ST_FULL_ON;
        end
      end
      `CPSC_ST_PROBE: begin
        // Own resume point, so the stop grant exit target survives a probe
        if (probe_done && !att_req) begin
          next_state = probe_return;
        end
      end
      default: begin
        next_state = `CPSC_ST_FULL_ON;
      end
    endcase
  end

  // Latched interrupts: cleared when taken in full-on, collected only while stopped or probing
  always @* begin
    next_latch_irq = latch_irq;
    if (irq_taken && (state == `CPSC_ST_FULL_ON)) begin
      next_latch_irq = 4'h0;
    end
    // A probe out of halt leaves interrupts to end the halt directly
    if (stopped || (state == `CPSC_ST_PROBE && probe_return != `CPSC_ST_HALT)) begin
      next_latch_irq = next_latch_irq | irq_now;
    end
  end

  // Power state, latched interrupts and the two resume points
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= `CPSC_ST_FULL_ON;
      return_state <= `CPSC_ST_FULL_ON;
      probe_return <= `CPSC_ST_FULL_ON;
      latch_irq <= 4'h0;
      mgmt_prev <= 1'b0;
    end else begin
      state <= next_state;
      latch_irq <= next_latch_irq;
      mgmt_prev <= mgmt_req;
      if (state == `CPSC_ST_FULL_ON && next_state == `CPSC_ST_DRAIN) begin
        return_state <= `CPSC_ST_FULL_ON;
      end else if (state == `CPSC_ST_HALT && next_state != `CPSC_ST_HALT) begin
        return_state <= `CPSC_ST_HALT;
      end
      if (next_state == `CPSC_ST_PROBE && state != `CPSC_ST_PROBE) begin
        probe_return <= state;
      end
    end
  end

  // Special cycle to request on this edge
  always @* begin
    next_special_cycle = `CPSC_CYC_NONE;
    next_special_valid = 1'b0;
    if (state == `CPSC_ST_FULL_ON && next_state == `CPSC_ST_HALT) begin
      next_special_cycle = `CPSC_CYC_HALT;
      next_special_valid = 1'b1;
    end else if (state == `CPSC_ST_DRAIN && (next_state == `CPSC_ST_STOP_GRANT
        || next_state == `CPSC_ST_SLEEP)) begin
      next_special_cycle = `CPSC_CYC_STOP_GRANT;
      next_special_valid = 1'b1;
    end
  end

  // One-cycle special cycle request to the bus unit
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      special_cycle <= `CPSC_CYC_NONE;
      special_cycle_valid <= 1'b0;
    end else begin
      special_cycle <= next_special_cycle;
      special_cycle_valid <= next_special_valid;
    end
  end

  // State and interrupt reporting
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_state <= `CPSC_ST_FULL_ON;
      core_run <= 1'b1;
      pll_run <= 1'b1;
      probe_enable <= 1'b1;
      mgmt_mode_enter <= 1'b0;
      reset_start <= 1'b0;
      pending_irq <= 4'h0;
    end else begin
      power_state <= next_state;
      core_run <= (next_state == `CPSC_ST_FULL_ON) || (next_state == `CPSC_ST_DRAIN);
      pll_run <= (next_state != `CPSC_ST_SLEEP);
      probe_enable <= (next_state != `CPSC_ST_SLEEP);
      mgmt_mode_enter <= mgmt_req && !mgmt_prev && (state == `CPSC_ST_FULL_ON);
      reset_start <= rst_req && (state != `CPSC_ST_FULL_ON || !reset_start);
      pending_irq <= (next_state == `CPSC_ST_FULL_ON) ? next_latch_irq : 4'h0;
    end
  end

  // Supply selection codes, constant once out of reset
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cache_supply_select <= 1'b0;
      core_voltage_code <= 4'h0;
    end else begin
      cache_supply_select <= CACHE_SEL_25V;
      core_voltage_code <= CORE_VID;
    end
  end
endmodule

// >>> cpsc_regs.vh
// Constants for the processor power-state sequencer
// Summary of operation
// - Stop request enters low power, Stop Grant
// - Management interrupt edge in full-on enters management mode
// - Cache select high 2.5V, low 3.3V
// - Four-bit core voltage code output
// - Full-on is the default state
// - Halt instruction issues Halt special cycle
// - Halt exits on init, irq, nmi, reset, mgmt
// - Drain bus cycles before Stop Grant cycle
// - Stop exit on release, resume boundary
// - Latch interrupts while stopped, service later
// - Reset while stopped returns to full-on
// - Probe state answers probes like full-on
// - After probe return to prior state
// - Attach request enters Probe state (code: from Halt and Stop Grant only, ignored in full-on, drain and sleep)
// - Halted: stop request toggles Stop Grant/Halt
`ifndef CPSC_REGS_VH
`define CPSC_REGS_VH
`define CPSC_ST_FULL_ON 3'h0
`define CPSC_ST_HALT 3'h1
`define CPSC_ST_DRAIN 3'h2
`define CPSC_ST_STOP_GRANT 3'h3
`define CPSC_ST_SLEEP 3'h4
`define CPSC_ST_PROBE 3'h5
`define CPSC_CYC_NONE 2'h0
`define CPSC_CYC_HALT 2'h1
`define CPSC_CYC_STOP_GRANT 2'h2
`define CPSC_IRQ_INIT 0
`define CPSC_IRQ_MASK 1
`define CPSC_IRQ_NMI 2
`define CPSC_IRQ_MGMT 3
`define CPSC_IRQ_W 4
`define CPSC_CORE_VID_DEFAULT 4'h5
`define CPSC_CACHE_SEL_DEFAULT 1'h1
`endif

// >>> cpsc_sys_model.sv
// System controller model: stop request, sleep select, probe attach
`timescale 1ns/100ps
module cpsc_sys_model (
  // Clock and commands
  input logic clk_sys,
  input logic [1:0] c_level,
  input logic probe_req,
  // Pins to the device
  output logic clock_stop_request_n = 1'h1,
  output logic sleep_select = 1'h0,
  output logic attach_request = 1'h0
);
  always @(negedge clk_sys) begin
    clock_stop_request_n <= c_level == 2'h0;
    sleep_select <= c_level == 2'h3;
    // No probes once asleep
    attach_request <= probe_req && !sleep_select;
  end
endmodule

// >>> cpsc_power_seq_assertions.sv
// Checker of the power-state sequencer ports
`timescale 1ns/100ps
module cpsc_power_seq_chk (
  // Clock, reset, inputs
  input logic clk_sys, rst_n, clock_stop_request_n, bus_busy,
  // Outputs
  input logic [1:0] special_cycle,
  input logic special_cycle_valid, pll_run, cache_supply_select,
  input logic [2:0] power_state,
  input logic [3:0] core_voltage_code
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [2:0] prior;
  always @(posedge clk_sys) if (power_state != 3'h5) prior <= power_state;
  sequence s_granted; $rose(power_state == 3'h3) && $past(power_state) == 3'h2; endsequence
  sequence s_halted; $rose(power_state == 3'h1) && $past(power_state) == 3'h0; endsequence
  property p_sg_cycle; s_granted |-> ##[0:1] special_cycle_valid && special_cycle == 2'h2; endproperty
  a_sg_cycle: assert property (p_sg_cycle) else $error("no stop grant cycle");
  property p_sg_idle; s_granted |-> !$past(bus_busy); endproperty
  a_sg_idle: assert property (p_sg_idle) else $error("grant with busy bus");
  property p_halt_cycle; s_halted |-> ##[0:1] special_cycle_valid && special_cycle == 2'h1; endproperty
  a_halt_cycle: assert property (p_halt_cycle) else $error("no halt cycle");
  property p_pll; power_state == 3'h1 |-> pll_run; endproperty
  a_pll: assert property (p_pll) else $error("loop off in halt");
  property p_supply; $past(rst_n) |-> cache_supply_select && core_voltage_code == 4'h5; endproperty
  a_supply: assert property (p_supply) else $error("bad supply code");
  property p_probe_ret; $fell(power_state == 3'h5) |-> power_state == prior; endproperty
  a_probe_ret: assert property (p_probe_ret) else $error("wrong state after probe");
  property p_stop_in;
    $fell(clock_stop_request_n) && power_state == 3'h0 && !bus_busy |-> ##[1:8] power_state inside {3'h2, 3'h3, 3'h4};
  endproperty
  a_stop_in: assert property (p_stop_in) else $error("stop request ignored");
  property p_stop_out;
    $rose(clock_stop_request_n) && power_state inside {3'h3, 3'h4} |-> ##[1:8] power_state inside {3'h0, 3'h1};
  endproperty
  a_stop_out: assert property (p_stop_out) else $error("stop not left");
endmodule
bind cpsc_power_seq cpsc_power_seq_chk u_chk (.clk_sys, .rst_n, .clock_stop_request_n, .bus_busy,
  .special_cycle, .special_cycle_valid, .pll_run, .cache_supply_select, .power_state, .core_voltage_code);

// >>> test_cpsc_power_seq.sv
// Self-checking bench of the power-state sequencer
`timescale 1ns/100ps
`include "cpsc_regs.vh"
module test_cpsc_power_seq;
  logic clk_sys = 1'h0, rst_n = 1'h0, probe_req = 1'h0, mgmt_interrupt_n = 1'h1, reset_pin_n = 1'h1;
  logic maskable_irq = 1'h0, nmi_irq = 1'h0, halt_instruction = 1'h0, irq_enabled = 1'h1;
  logic bus_busy = 1'h0, probe_done = 1'h0, irq_taken = 1'h0, clock_stop_request_n, sleep_select;
  logic attach_request, special_cycle_valid, core_run, pll_run, probe_enable, mgmt_mode_enter;
  logic reset_start, cache_supply_select, soft_init_n = 1'h1;
  logic [1:0] c_level = 2'h0, special_cycle;
  logic [2:0] power_state;
  logic [3:0] pending_irq, core_voltage_code;
  int n_mismatch = 0, total_checks = 0, cycles = 0;
  initial forever #5 clk_sys = ~clk_sys;
  cpsc_sys_model u_sys (.clk_sys, .c_level, .probe_req, .clock_stop_request_n, .sleep_select, .attach_request);
  cpsc_power_seq u_dut (.clk_sys, .rst_n, .clock_stop_request_n, .mgmt_interrupt_n, .soft_init_n,
    .reset_pin_n, .maskable_irq, .nmi_irq, .attach_request, .sleep_select, .halt_instruction, .irq_enabled,
    .bus_busy, .probe_done, .irq_taken, .special_cycle, .special_cycle_valid, .power_state, .core_run,
    .pll_run, .probe_enable, .mgmt_mode_enter, .reset_start, .pending_irq, .cache_supply_select,
    .core_voltage_code);
  task chk(input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wait_st(input logic [2:0] s);
    for (int i = 0; i < 20 && power_state !== s; i++) @(negedge clk_sys);
    chk(power_state, s);
  endtask
  task wait_cyc(input logic [1:0] c);
    for (int i = 0; i < 20 && special_cycle_valid !== 1'h1; i++) @(negedge clk_sys);
    chk({special_cycle_valid, special_cycle}, {1'h1, c});
  endtask
  task t_reset;
    repeat (2) @(negedge clk_sys);
    chk({power_state, core_run, pll_run, probe_enable}, 6'h07);
    chk({cache_supply_select, core_voltage_code}, {`CPSC_CACHE_SEL_DEFAULT, `CPSC_CORE_VID_DEFAULT});
    mgmt_interrupt_n <= 1'h0;
    for (int i = 0; i < 8 && mgmt_mode_enter !== 1'h1; i++) @(negedge clk_sys);
    chk(mgmt_mode_enter, 1'h1);
    mgmt_interrupt_n <= 1'h1;
  endtask
  task t_grant;
    bus_busy <= 1'h1;
    c_level <= 2'h2;
    wait_st(`CPSC_ST_DRAIN);
    repeat (4) @(negedge clk_sys);
    chk({power_state, special_cycle_valid}, {`CPSC_ST_DRAIN, 1'h0});
    bus_busy <= 1'h0;
    wait_cyc(`CPSC_CYC_STOP_GRANT);
    wait_st(`CPSC_ST_STOP_GRANT);
    maskable_irq <= 1'h1;
    nmi_irq <= 1'h1;
    soft_init_n <= 1'h0;
    probe_req <= 1'h1;
    wait_st(`CPSC_ST_PROBE);
    chk(probe_enable, 1'h1);
    maskable_irq <= 1'h0;
    nmi_irq <= 1'h0;
    soft_init_n <= 1'h1;
    probe_req <= 1'h0;
    repeat (6) @(negedge clk_sys);
    probe_done <= 1'h1;
    @(negedge clk_sys);
    probe_done <= 1'h0;
    wait_st(`CPSC_ST_STOP_GRANT);
    c_level <= 2'h0;
    wait_st(`CPSC_ST_FULL_ON);
    chk(pending_irq, 4'h7);
    irq_taken <= 1'h1;
    @(negedge clk_sys);
    irq_taken <= 1'h0;
    @(negedge clk_sys);
    chk(pending_irq, 4'h0);
  endtask
  task t_halt;
    halt_instruction <= 1'h1;
    @(negedge clk_sys);
    halt_instruction <= 1'h0;
    wait_cyc(`CPSC_CYC_HALT);
    wait_st(`CPSC_ST_HALT);
    chk(pll_run, 1'h1);
    c_level <= 2'h2;
    wait_st(`CPSC_ST_STOP_GRANT);
    c_level <= 2'h0;
    wait_st(`CPSC_ST_HALT);
    nmi_irq <= 1'h1;
    wait_st(`CPSC_ST_FULL_ON);
    nmi_irq <= 1'h0;
  endtask
  task t_sleep;
    c_level <= 2'h3;
    wait_st(`CPSC_ST_SLEEP);
    chk({pll_run, probe_enable}, 2'h0);
    reset_pin_n <= 1'h0;
    wait_st(`CPSC_ST_FULL_ON);
    chk(reset_start, 1'h1);
    reset_pin_n <= 1'h1;
    wait_st(`CPSC_ST_SLEEP);
    c_level <= 2'h0;
    wait_st(`CPSC_ST_FULL_ON);
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    rst_n <= 1'h1;
    t_reset;
    t_grant;
    t_halt;
    t_sleep;
    conclude;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      conclude;
    end
  end
endmodule
